// File: rtl/timer_cfg.svh
// Offsets, field positions, reset values and divider masks of the 8-bit timer
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ------------------------------------------------------------
// Register offsets on the special function register port
// ------------------------------------------------------------
`define TIMER_CONTROL_ADDR 8'hE1
`define REFERENCE_VALUE_ADDR 8'hE2
`define COUNT_VALUE_ADDR 8'hE3

// ------------------------------------------------------------
// Control register fields and reset value
// ------------------------------------------------------------
`define TIMER_CONTROL_RESET 8'h00
`define CTL_CLK_SEL_HI 7
`define CTL_CLK_SEL_LO 6
`define CTL_MODE_HI 5
`define CTL_MODE_LO 4
`define CTL_CLEAR_COUNT_BIT 3
`define CTL_OVF_EN_BIT 2
`define CTL_MATCH_EN_BIT 1
`define CTL_MATCH_CLR_BIT 0
// Bits that hold state; clear strobes read as zero
`define CTL_STORED_MASK 8'hF6

// ------------------------------------------------------------
// Counter and prescaler constants
// ------------------------------------------------------------
`define COUNT_RESET 8'h00
`define COUNT_TOP 8'hFF
`define PRESCALE_WIDTH 10
`define DIV1024_MASK 10'h3FF
`define DIV256_MASK 10'h0FF
`define DIV64_MASK 10'h03F

`endif

// File: rtl/timer_pkg.sv
// Types shared by the 8-bit timer modules
package timer_pkg;

	// Operating mode, Gray coded along interval, capture, PWM
	typedef enum logic [1:0] {
		MODE_INTERVAL = 2'h0,
		MODE_CAPTURE_FALL = 2'h1,
		MODE_CAPTURE_RISE = 2'h3,
		MODE_PWM = 2'h2
	} timer_mode_e;

	// Timer clock source
	typedef enum logic [1:0] {
		CLK_DIV1024 = 2'h0,
		CLK_DIV256 = 2'h1,
		CLK_DIV64 = 2'h3,
		CLK_EXTERNAL = 2'h2
	} clock_sel_e;

endpackage

// File: rtl/timer_tick_if.sv
// Timer tick and capture edge carrier between clock generator and core
`timescale 1ns/1ps
`default_nettype none

interface timer_tick_if;
	import timer_pkg::*;
	clock_sel_e clk_sel;
	logic tick;
	logic cap_rise;
	logic cap_fall;
	modport gen (input clk_sel, output tick, output cap_rise, output cap_fall);
	modport core (output clk_sel, input tick, input cap_rise, input cap_fall);
endinterface

`default_nettype wire

// File: rtl/timer_clock_gen.sv
// Prescaler, clock multiplexer and pin synchronisers of the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module timer_clock_gen
	import timer_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ext_clock_pin_in,
	input wire logic capture_in_pin_in,
	timer_tick_if.gen tick_port
);

	typedef struct packed {
		logic [`PRESCALE_WIDTH-1:0] prescale;
		logic [1:0] ext_sync;
		logic ext_prev;
		logic [1:0] cap_sync;
		logic cap_prev;
	} gen_state_s;

	gen_state_s state;
	gen_state_s next_state;
	logic div_hit;

	// ------------------------------------------------------------
	// Clock source selection
	// ------------------------------------------------------------
	always_comb begin
		case (tick_port.clk_sel)
			CLK_DIV1024: div_hit = (state.prescale & `DIV1024_MASK) == `DIV1024_MASK;
			CLK_DIV256: div_hit = (state.prescale & `DIV256_MASK) == `DIV256_MASK;
			CLK_DIV64: div_hit = (state.prescale & `DIV64_MASK) == `DIV64_MASK;
			CLK_EXTERNAL: div_hit = state.ext_sync[1] & ~state.ext_prev;
			default: div_hit = 1'b0;
		endcase
	end

	// Next state: free prescaler, two-stage pin synchronisers
	always_comb begin
		next_state = state;
		next_state.prescale = state.prescale + `PRESCALE_WIDTH'(1);
		next_state.ext_sync = {state.ext_sync[0], ext_clock_pin_in};
		next_state.ext_prev = state.ext_sync[1];
		next_state.cap_sync = {state.cap_sync[0], capture_in_pin_in};
		next_state.cap_prev = state.cap_sync[1];
	end

	// State register
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Edge pulses on the synchronised side only
	assign tick_port.tick = div_hit;
	assign tick_port.cap_rise = state.cap_sync[1] & ~state.cap_prev;
	assign tick_port.cap_fall = ~state.cap_sync[1] & state.cap_prev;

endmodule // timer_clock_gen

`default_nettype wire

// File: rtl/eight_bit_timer.sv
// 8-bit timer/counter with interval, PWM and capture modes
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module eight_bit_timer
	import timer_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Special function register port
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	// Interrupt requests and service acknowledges
	output logic overflow_irq_out,
	output logic match_capture_irq_out,
	input wire logic overflow_ack_in,
	input wire logic match_capture_ack_in,
	// Pins
	input wire logic ext_clock_pin_in,
	input wire logic capture_in_pin_in,
	input wire logic [1:0] port0_high_config_in,
	output logic toggle_out_pin_out,
	output logic toggle_out_pin_oe_n_out,
	output logic pwm_output_out
);

	typedef struct packed {
		logic [7:0] timer_control;
		logic [7:0] count_value;
		logic [7:0] reference_value;
		logic toggle;
		logic pwm_level;
		logic ovf_pending;
		logic match_pending;
		logic [7:0] rdata;
	} timer_state_s;

	timer_state_s state;
	timer_state_s next_state;
	timer_tick_if tick_bus();

	timer_mode_e mode;
	logic ctl_wr;
	logic ref_wr;
	logic counter_clear;
	logic match;
	logic overflow_event;
	logic match_event;
	logic capture_edge;

	// ------------------------------------------------------------
	// Prescaler and pin synchronisers
	// ------------------------------------------------------------
	timer_clock_gen u_clock_gen (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ext_clock_pin_in(ext_clock_pin_in),
		.capture_in_pin_in(capture_in_pin_in),
		.tick_port(tick_bus.gen)
	);

	// Control field decode
	assign tick_bus.clk_sel = clock_sel_e'(state.timer_control[`CTL_CLK_SEL_HI:`CTL_CLK_SEL_LO]);
	assign mode = timer_mode_e'(state.timer_control[`CTL_MODE_HI:`CTL_MODE_LO]);

	// ------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------
	assign ctl_wr = sfr_wr_in && (sfr_addr_in == `TIMER_CONTROL_ADDR);
	assign ref_wr = sfr_wr_in && (sfr_addr_in == `REFERENCE_VALUE_ADDR);
	assign counter_clear = ctl_wr && sfr_wdata_in[`CTL_CLEAR_COUNT_BIT];

	// Match and event terms; overflow and compare events qualified by the timer tick, capture edges not
	assign match = state.count_value == state.reference_value;
	assign capture_edge = (mode == MODE_CAPTURE_RISE) ? tick_bus.cap_rise :
		(mode == MODE_CAPTURE_FALL) ? tick_bus.cap_fall : 1'b0;
	assign overflow_event = tick_bus.tick && (state.count_value == `COUNT_TOP) &&
		!(mode == MODE_INTERVAL && match) && !counter_clear;
	always_comb begin
		case (mode)
			MODE_INTERVAL: match_event = tick_bus.tick && match;
			MODE_PWM: match_event = tick_bus.tick && match;
			MODE_CAPTURE_FALL: match_event = capture_edge;
			MODE_CAPTURE_RISE: match_event = capture_edge;
			default: match_event = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;

		// Control register; clear strobes are not stored
		if (ctl_wr) begin
			next_state.timer_control = sfr_wdata_in & `CTL_STORED_MASK;
		end

		// Counter: clear strobe wins, else advance on tick, or return to zero on a tick with an interval match
		if (counter_clear) begin
			next_state.count_value = `COUNT_RESET;
		end else if (tick_bus.tick) begin
			if (mode == MODE_INTERVAL && match) begin
				next_state.count_value = `COUNT_RESET;
			end else begin
				next_state.count_value = state.count_value + 8'h01;
			end
		end

		// Reference: captured value wins over a software write
		if (capture_edge) begin
			next_state.reference_value = state.count_value;
		end else if (ref_wr) begin
			next_state.reference_value = sfr_wdata_in;
		end

		// Interval toggle output
		if (mode == MODE_INTERVAL && tick_bus.tick && match && !counter_clear) begin
			next_state.toggle = ~state.toggle;
		end

		// PWM level registered from the current compare
		next_state.pwm_level = state.reference_value > state.count_value;

		// Overflow pending: service ack clears, a new event wins
		if (overflow_event) begin
			next_state.ovf_pending = 1'b1;
		end else if (overflow_ack_in) begin
			next_state.ovf_pending = 1'b0;
		end

		// Match/capture pending: ack or software clear, event wins unless a counter clear strobe comes with it
		if (match_event && !counter_clear) begin
			next_state.match_pending = 1'b1;
		end else if (match_capture_ack_in) begin
			next_state.match_pending = 1'b0;
		end else if (ctl_wr && sfr_wdata_in[`CTL_MATCH_CLR_BIT]) begin
			next_state.match_pending = 1'b0;
		end

		// Registered read data
		case (sfr_addr_in)
			`TIMER_CONTROL_ADDR: next_state.rdata = state.timer_control;
			`REFERENCE_VALUE_ADDR: next_state.rdata = state.reference_value;
			`COUNT_VALUE_ADDR: next_state.rdata = state.count_value;
			default: next_state.rdata = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state.timer_control <= `TIMER_CONTROL_RESET;
			state.count_value <= `COUNT_RESET;
			state.reference_value <= 8'h00;
			state.toggle <= 1'b0;
			state.pwm_level <= 1'b0;
			state.ovf_pending <= 1'b0;
			state.match_pending <= 1'b0;
			state.rdata <= 8'h00;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Requests gated by their enables
	assign overflow_irq_out = state.ovf_pending && state.timer_control[`CTL_OVF_EN_BIT];
	assign match_capture_irq_out = state.match_pending && state.timer_control[`CTL_MATCH_EN_BIT];

	// Pin driven only when configured as push-pull output
	assign toggle_out_pin_oe_n_out = ~port0_high_config_in[1];
	assign toggle_out_pin_out = (mode == MODE_PWM) ? state.pwm_level : state.toggle;
	assign pwm_output_out = state.pwm_level;
	assign sfr_rdata_out = state.rdata;

endmodule // eight_bit_timer

`default_nettype wire

// File: verif/timer_chk.sv
// Port checker for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module timer_chk (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic overflow_irq_out,
	input wire logic match_capture_irq_out,
	input wire logic overflow_ack_in,
	input wire logic match_capture_ack_in,
	input wire logic [1:0] port0_high_config_in,
	input wire logic toggle_out_pin_out,
	input wire logic toggle_out_pin_oe_n_out,
	input wire logic pwm_output_out
);
	logic [7:0] ctl;
	logic [7:0] ref_sh;

	// Shadows of the last written control and reference values
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctl <= 8'h00;
			ref_sh <= 8'h00;
		end else if (sfr_wr_in) begin
			if (sfr_addr_in == `TIMER_CONTROL_ADDR) ctl <= sfr_wdata_in;
			if (sfr_addr_in == `REFERENCE_VALUE_ADDR) ref_sh <= sfr_wdata_in;
		end
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	// Control write followed by a read of the same place
	sequence s_ctl_wr;
		sfr_wr_in && sfr_addr_in == `TIMER_CONTROL_ADDR;
	endsequence
	sequence s_ctl_rd;
		!sfr_wr_in && sfr_addr_in == `TIMER_CONTROL_ADDR;
	endsequence

	ctl_readback_a: assert property (s_ctl_wr ##1 s_ctl_rd
		|=> sfr_rdata_out == ($past(sfr_wdata_in, 2) & `CTL_STORED_MASK)) else $error("control readback");
	unmapped_zero_a: assert property (!(sfr_addr_in inside {8'hE1, 8'hE2, 8'hE3})
		|=> sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
	ovf_service_a: assert property (overflow_ack_in && overflow_irq_out |=> !overflow_irq_out)
		else $error("overflow not cleared by service");
	match_service_a: assert property (match_capture_ack_in && match_capture_irq_out
		|=> !match_capture_irq_out) else $error("match not cleared by service");
	match_gate_a: assert property (sfr_wr_in && sfr_addr_in == 8'hE1 && !sfr_wdata_in[1]
		|=> !match_capture_irq_out) else $error("match request while disabled");
	toggle_match_a: assert property (ctl[5:4] == 2'b00 && ctl[1] && $past(ctl, 2) == ctl
		&& $changed(toggle_out_pin_out) |-> match_capture_irq_out) else $error("toggle without match");
	pwm_floor_a: assert property (ctl[5:4] == 2'b10 && ref_sh == 8'h00 && $past(ref_sh, 2) == 8'h00
		|-> !pwm_output_out) else $error("pwm high with zero reference");
	pin_drive_a: assert property (port0_high_config_in[1] [*3] |-> !toggle_out_pin_oe_n_out)
		else $error("pin not driven");
endmodule // timer_chk

bind eight_bit_timer timer_chk u_chk (.*);

`default_nettype wire

// File: verif/timer_pins_model.sv
// External clock source, capture driver and pull-up load on the timer pins
`timescale 1ns/1ps
`default_nettype none

module timer_pins_model (
	input wire logic core_clk_in,
	input wire logic toggle_out_pin_in,
	input wire logic toggle_oe_n_in,
	output logic ext_clock_pin_out,
	output logic capture_in_pin_out,
	output logic pin_level_out
);
	// Pull-up holds the pin high while the timer leaves it
	assign pin_level_out = toggle_oe_n_in ? 1'b1 : toggle_out_pin_in;

	initial begin
		ext_clock_pin_out = 1'b0;
		capture_in_pin_out = 1'b0;
	end

	// Burst of clock edges; the line rests low between bursts
	task automatic clocks(input int n);
		repeat (n) begin
			@(negedge core_clk_in) ext_clock_pin_out = 1'b1;
			repeat (8) @(negedge core_clk_in);
			ext_clock_pin_out = 1'b0;
			repeat (8) @(negedge core_clk_in);
		end
	endtask

	// New capture level, held past the synchroniser
	task automatic cap(input logic v);
		@(negedge core_clk_in) capture_in_pin_out = v;
		repeat (8) @(negedge core_clk_in);
	endtask
endmodule // timer_pins_model

`default_nettype wire

// File: verif/tb_eight_bit_timer.sv
// Self-checking bench for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module tb_eight_bit_timer;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic ovf_ack = 1'b0;
	logic mc_ack = 1'b0;
	logic [1:0] cfg = 2'b00;
	logic [7:0] rdata;
	logic ovf_irq;
	logic mc_irq;
	logic ext_clk;
	logic cap;
	logic tog;
	logic oe_n;
	logic pwm;
	logic pin;
	int errors = 0;
	int num_checks = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	eight_bit_timer dut (.core_clk_in(clk), .rst_in(rst), .sfr_addr_in(addr), .sfr_wr_in(wr),
		.sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .overflow_irq_out(ovf_irq), .match_capture_irq_out(mc_irq),
		.overflow_ack_in(ovf_ack), .match_capture_ack_in(mc_ack), .ext_clock_pin_in(ext_clk),
		.capture_in_pin_in(cap), .port0_high_config_in(cfg), .toggle_out_pin_out(tog),
		.toggle_out_pin_oe_n_out(oe_n), .pwm_output_out(pwm));
	timer_pins_model pins (.core_clk_in(clk), .toggle_out_pin_in(tog), .toggle_oe_n_in(oe_n),
		.ext_clock_pin_out(ext_clk), .capture_in_pin_out(cap), .pin_level_out(pin));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic wait_mc(output int n);
		n = 0;
		while (mc_irq !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic t_reset;
		logic [7:0] d;
		rd_reg(`TIMER_CONTROL_ADDR, d);
		chk(d, 8'h00, "control reset");
		rd_reg(8'h10, d);
		chk(d, 8'h00, "unmapped");
		chk({mc_irq, ovf_irq, pin}, 3'b001, "idle pins");
		$display("reset test done");
	endtask

	task automatic t_interval;
		logic [7:0] d;
		int n;
		wr_reg(`REFERENCE_VALUE_ADDR, 8'h03);
		cfg = 2'b10;
		wr_reg(`TIMER_CONTROL_ADDR, 8'hCB); // Div 64, interval, match irq, clears
		wait_mc(n);
		chk({mc_irq, tog}, 2'b11, "match");
		rd_reg(`COUNT_VALUE_ADDR, d);
		chk(d, 8'h00, "count after match");
		@(negedge clk) mc_ack = 1'b1;
		@(negedge clk) mc_ack = 1'b0;
		chk(mc_irq, 1'b0, "service clear");
		wait_mc(n);
		chk(n[15:0], 16'd252, "period");
		chk(tog, 1'b0, "toggle back");
		wr_reg(`TIMER_CONTROL_ADDR, 8'hC0);
		chk(mc_irq, 1'b0, "masked");
		wr_reg(`TIMER_CONTROL_ADDR, 8'hC2);
		chk(mc_irq, 1'b1, "unmasked");
		wr_reg(`TIMER_CONTROL_ADDR, 8'hC3);
		chk(mc_irq, 1'b0, "software clear");
		$display("interval test done");
	endtask

	task automatic t_ext;
		logic [7:0] d;
		wr_reg(`REFERENCE_VALUE_ADDR, 8'hFF);
		wr_reg(`TIMER_CONTROL_ADDR, 8'h88); // External clock, clear count
		pins.clocks(5);
		rd_reg(`COUNT_VALUE_ADDR, d);
		chk(d, 8'h05, "external count");
		wr_reg(`COUNT_VALUE_ADDR, 8'hAA);
		rd_reg(`COUNT_VALUE_ADDR, d);
		chk(d, 8'h05, "count read only");
		wr_reg(`TIMER_CONTROL_ADDR, 8'h88);
		rd_reg(`COUNT_VALUE_ADDR, d);
		chk(d, 8'h00, "count clear");
		$display("external clock test done");
	endtask

	task automatic t_pwm;
		int hp;
		int hw;
		wr_reg(`REFERENCE_VALUE_ADDR, 8'h00);
		wr_reg(`TIMER_CONTROL_ADDR, 8'hEC); // Div 64, PWM, overflow irq
		repeat (300) @(negedge clk);
		chk(pwm, 1'b0, "pwm floor");
		wr_reg(`REFERENCE_VALUE_ADDR, 8'h80);
		repeat (4) @(negedge clk);
		hp = 0;
		hw = 0;
		repeat (16384) begin
			@(negedge clk);
			hp += pin;
			hw += pwm;
		end
		chk(hp[15:0], 16'd8192, "pin high time");
		chk(hw[15:0], 16'd8192, "pwm high time");
		chk(ovf_irq, 1'b1, "wrap overflow");
		@(negedge clk) ovf_ack = 1'b1;
		@(negedge clk) ovf_ack = 1'b0;
		chk(ovf_irq, 1'b0, "overflow service");
		$display("pwm test done");
	endtask

	task automatic t_capture;
		logic [7:0] d;
		wr_reg(`TIMER_CONTROL_ADDR, 8'hBB); // External clock, rising capture
		chk(mc_irq, 1'b0, "pending cleared");
		pins.clocks(7);
		pins.cap(1'b1);
		rd_reg(`REFERENCE_VALUE_ADDR, d);
		chk(d, 8'h07, "rising capture");
		chk(mc_irq, 1'b1, "capture request");
		wr_reg(`TIMER_CONTROL_ADDR, 8'h93); // Falling capture
		pins.clocks(3);
		pins.cap(1'b0);
		rd_reg(`REFERENCE_VALUE_ADDR, d);
		chk(d, 8'h0A, "falling capture");
		$display("capture test done");
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_interval();
		t_ext();
		t_pwm();
		t_capture();
		report_and_stop();
	end

	// Watchdog at about twice the expected run
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		report_and_stop();
	end
endmodule // tb_eight_bit_timer

`default_nettype wire
